/* File: hw/efflag_pkg.sv */
/*
  Package for the encoder index and field flag block: register indices,
  field positions, reset values, threshold table, timing counts, states.
  Assumes a 125 MHz core clock.
*/
package efflag_pkg;
  localparam int CLK_MHZ = 125;
  // Register indices; the 5-bit address is the register number
  localparam logic [4:0] ADDR_THRESH = 5'h06;
  localparam logic [4:0] ADDR_STATUS = 5'h1B;
  localparam logic [4:0] ADDR_PPT_LO = 5'h04;
  localparam logic [4:0] ADDR_PPT_HI = 5'h05;
  // SPI command codes (top three bits of the first byte)
  localparam logic [2:0] CMD_READ  = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  // Field positions in the threshold register
  localparam int LOW_THR_LSB  = 5;
  localparam int HIGH_THR_LSB = 2;
  // Flag positions in the status register
  localparam int HIGH_FLAG_BIT = 7;
  localparam int LOW_FLAG_BIT  = 6;
  // Reset values
  localparam logic [7:0] THRESH_RESET = 8'h1C;
  localparam logic [5:0] PPT_RESET    = 6'h3F;
  // Field level in mT, rising and falling, per threshold code
  localparam int FIELD_W = 8;
  localparam logic [FIELD_W-1:0] RISE_MT [8] =
    '{8'h1A, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7E};
  localparam logic [FIELD_W-1:0] FALL_MT [8] =
    '{8'h14, 8'h23, 8'h32, 8'h40, 8'h4E, 8'h5C, 8'h6A, 8'h78};
  // Quadrature update period
  localparam int ABZ_PERIOD_NS = 64;
  localparam int ABZ_CYCLES    = (ABZ_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int ANGLE_W = 8;
  // Serial shifter states
  typedef enum logic [2:0] {
    EFF_IDLE = 3'b001,
    EFF_SHIFT = 3'b010,
    EFF_DONE = 3'b100
  } efflag_spi_state_t;
endpackage : efflag_pkg

/* File: hw/efflag_field_cmp.sv */
/*
  One field comparator with hysteresis for one alarm flag.
  Assumes the field magnitude is synchronous to clk_in.
*/
`timescale 1ns/1ns
module efflag_field_cmp
  import efflag_pkg::*;
#(
  parameter bit ABOVE = 1'b1
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // Field and code
  input  wire logic [FIELD_W-1:0] field_in,
  input  wire logic [2:0]         code_in,
  // Flag
  output logic                    flag_out
);
  logic flag_ff;
  logic nxt_flag;

  always_comb begin
    nxt_flag = flag_ff;
    if (ABOVE) begin
      // Set above rising level, clear below falling level
      if (field_in > RISE_MT[code_in])
        nxt_flag = 1'b1;
      else if (field_in < FALL_MT[code_in])
        nxt_flag = 1'b0;
    end else begin
      // Set below falling level, clear above rising level
      if (field_in < FALL_MT[code_in])
        nxt_flag = 1'b1;
      else if (field_in > RISE_MT[code_in])
        nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      flag_ff <= ABOVE ? 1'b0 : 1'b1;
    else
      flag_ff <= nxt_flag;
  end

  assign flag_out = flag_ff;
endmodule : efflag_field_cmp

/* File: hw/efflag_top.sv */
/*
  Encoder index and field flag block: ABZ quadrature generation from an
  angle, two field alarm flags with hysteresis, SPI slave register access.
  Assumes angle and field come from on-chip logic on clk_in; SPI pins are
  asynchronous and are synchronised here. SPI mode 0, MSB first.
*/
`timescale 1ns/1ns
module efflag_top
  import efflag_pkg::*;
#(
  parameter int UPDATE_CYCLES = ABZ_CYCLES
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // Sensor datapath
  input  wire logic [ANGLE_W-1:0] angle_in,
  input  wire logic [FIELD_W-1:0] field_in,
  // SPI pins
  input  wire logic               spi_sclk_in,
  input  wire logic               spi_cs_n_in,
  input  wire logic               spi_mosi_in,
  output logic                    spi_miso_out,
  output logic                    spi_miso_oe_out,
  // Encoder outputs
  output logic                    enc_a_out,
  output logic                    enc_b_out,
  output logic                    enc_z_out,
  // Field flag pins
  output logic                    high_field_flag_out,
  output logic                    low_field_flag_out
);
  // Synchronisers: stage 1 feeds only stage 2
  logic [2:0] sync1_ff, sync2_ff, nxt_sync1;
  logic       sclk_d_ff;
  always_comb nxt_sync1 = {spi_sclk_in, spi_cs_n_in, spi_mosi_in};
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // Idle pin levels, so no false SCLK edge follows reset
      sync1_ff  <= 3'h2;
      sync2_ff  <= 3'h2;
      sclk_d_ff <= 1'b0;
    end else begin
      sync1_ff  <= nxt_sync1;
      sync2_ff  <= sync1_ff;
      sclk_d_ff <= sync2_ff[2];
    end
  end
  logic sclk_s, cs_n_s, mosi_s, sclk_rise, sclk_fall;
  assign sclk_s    = sync2_ff[2];
  assign cs_n_s    = sync2_ff[1];
  assign mosi_s    = sync2_ff[0];
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;

  // Field flags
  logic [7:0] thresh_ff;
  logic       high_flag, low_flag;
  efflag_field_cmp #(.ABOVE(1'b1)) u_high (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .field_in (field_in),
    .code_in  (thresh_ff[HIGH_THR_LSB +: 3]),
    .flag_out (high_flag)
  );
  // Separate comparator, no ordering check between codes
  efflag_field_cmp #(.ABOVE(1'b0)) u_low (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .field_in (field_in),
    .code_in  (thresh_ff[LOW_THR_LSB +: 3]),
    .flag_out (low_flag)
  );
  assign high_field_flag_out = high_flag;
  assign low_field_flag_out  = low_flag;

  function automatic logic [7:0] reg_read(input logic [4:0] a,
                                          input logic [7:0] thr,
                                          input logic [5:0] pulses_per_turn_code,
                                          input logic hi,
                                          input logic lo);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_THRESH: v = {thr[7:2], 2'b00};
      ADDR_PPT_LO: v = {pulses_per_turn_code[1:0], 6'h00};
      ADDR_PPT_HI: v = {4'h0, pulses_per_turn_code[5:2]};
      ADDR_STATUS: begin
        v[HIGH_FLAG_BIT] = hi;
        v[LOW_FLAG_BIT]  = lo;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // SPI slave: 16-bit frames; a read answers in the next frame
  efflag_spi_state_t st_ff, nxt_st;
  logic [15:0] rx_ff, nxt_rx;
  logic [15:0] tx_ff, nxt_tx;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [7:0]  reply_ff, nxt_reply;
  logic [7:0]  nxt_thresh;
  logic [5:0]  ppt_ff, nxt_ppt;
  logic [15:0] word;
  assign word = {rx_ff[14:0], mosi_s};

  always_comb begin
    nxt_st     = st_ff;
    nxt_rx     = rx_ff;
    nxt_tx     = tx_ff;
    nxt_cnt    = cnt_ff;
    nxt_reply  = reply_ff;
    nxt_thresh = thresh_ff;
    nxt_ppt    = ppt_ff;
    case (st_ff)
      EFF_IDLE: begin
        if (!cs_n_s) begin
          nxt_st  = EFF_SHIFT;
          nxt_cnt = 4'h0;
          // Previous frame's reply (read data or write echo) goes out this frame
          nxt_tx  = {reply_ff, 8'h00};
        end
      end
      EFF_SHIFT: begin
        if (cs_n_s) begin
          nxt_st = EFF_IDLE;
        end else if (sclk_rise) begin
          nxt_rx  = word;
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == 4'hF) begin
            nxt_st = EFF_DONE;
            if (word[15:13] == CMD_READ) begin
              nxt_reply = reg_read(word[12:8], thresh_ff, ppt_ff,
                                   high_flag, low_flag);
            end else if (word[15:13] == CMD_WRITE) begin
              // Status is read-only: no write path to it
              nxt_reply = word[7:0];
              if (word[12:8] == ADDR_THRESH)
                nxt_thresh = {word[7:2], 2'b00};
              else if (word[12:8] == ADDR_PPT_LO)
                nxt_ppt[1:0] = word[7:6];
              else if (word[12:8] == ADDR_PPT_HI)
                nxt_ppt[5:2] = word[3:0];
            end
          end
        end else if (sclk_fall) begin
          nxt_tx = {tx_ff[14:0], 1'b0};
        end
      end
      EFF_DONE: begin
        if (cs_n_s)
          nxt_st = EFF_IDLE;
      end
      default: nxt_st = EFF_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff     <= EFF_IDLE;
      rx_ff     <= 16'h0000;
      tx_ff     <= 16'h0000;
      cnt_ff    <= 4'h0;
      reply_ff  <= 8'h00;
      thresh_ff <= THRESH_RESET;
      ppt_ff    <= PPT_RESET;
    end else begin
      st_ff     <= nxt_st;
      rx_ff     <= nxt_rx;
      tx_ff     <= nxt_tx;
      cnt_ff    <= nxt_cnt;
      reply_ff  <= nxt_reply;
      thresh_ff <= nxt_thresh;
      ppt_ff    <= nxt_ppt;
    end
  end
  assign spi_miso_out    = tx_ff[15];
  assign spi_miso_oe_out = ~cs_n_s;

  // Quadrature: 4*(ppt+1) quarter states per turn
  logic [15:0] upd_ff, nxt_upd;
  logic [7:0]  pulses;
  logic [15:0] prod;
  logic [7:0]  quarter;
  logic [2:0]  abz_ff, nxt_abz;
  assign pulses  = {2'b00, ppt_ff} + 8'h01;
  assign prod    = 16'(angle_in) * {6'h00, pulses, 2'b00};
  assign quarter = prod[15:8];

  always_comb begin
    nxt_upd = upd_ff + 16'h0001;
    nxt_abz = abz_ff;
    if (upd_ff >= 16'(UPDATE_CYCLES - 1)) begin
      nxt_upd = 16'h0000;
      // Gray sequence per quarter gives 90 degree phase
      nxt_abz[0] = ~quarter[1];
      nxt_abz[1] = quarter[1] ^ quarter[0];
      // Index spans the zero quarter, so any direction sees it once
      nxt_abz[2] = (quarter == 8'h00);
      // Entering it forward, A rises in the same update
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      upd_ff <= 16'h0000;
      abz_ff <= 3'h0;
    end else begin
      upd_ff <= nxt_upd;
      abz_ff <= nxt_abz;
    end
  end
  assign enc_a_out = abz_ff[0];
  assign enc_b_out = abz_ff[1];
  assign enc_z_out = abz_ff[2];
endmodule : efflag_top

/* File: test/efflag_top_asserts.sv */
/* Port checker for efflag_top: field flags, encoder edges, SPI enable.
   Assumes the bind below and field levels given in mT. */
`timescale 1ns/1ns
module efflag_top_asserts
  import efflag_pkg::*;
#(
  parameter int UPDATE_CYCLES = ABZ_CYCLES
) (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // Watched inputs
  input wire logic [7:0] field_in,
  input wire logic       spi_cs_n_in,
  // Watched outputs
  input wire logic       spi_miso_oe_out,
  input wire logic       enc_a_out,
  input wire logic       enc_b_out,
  input wire logic       enc_z_out,
  input wire logic       high_field_flag_out,
  input wire logic       low_field_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [2:0] abz_ff;
  logic [7:0] gap_ff;
  logic [7:0] nxt_gap;
  logic       chg;
  // Saturates, so a slow turn never wraps it into a false gap
  always_comb begin
    chg = abz_ff != {enc_a_out, enc_b_out, enc_z_out};
    nxt_gap = chg ? 8'h00 : gap_ff + {7'h00, gap_ff != 8'hFF};
    if (!rst_n_in) nxt_gap = 8'hFF;
  end
  always_ff @(posedge clk_in) begin
    abz_ff <= {enc_a_out, enc_b_out, enc_z_out};
    gap_ff <= nxt_gap;
  end
  a_high_sure_set: assert property (
    $past(field_in) > 8'h7E |-> high_field_flag_out)
    else $error("high flag clear above top level");
  a_low_sure_set: assert property (
    $past(field_in) < 8'h14 |-> low_field_flag_out)
    else $error("low flag clear below bottom level");
  a_high_sure_clear: assert property (
    $past(field_in) < 8'h14 |-> !high_field_flag_out)
    else $error("high flag set below bottom level");
  a_low_sure_clear: assert property (
    $past(field_in) > 8'h7E |-> !low_field_flag_out)
    else $error("low flag set above top level");
  a_high_rise_lvl: assert property (
    $rose(high_field_flag_out) |-> $past(field_in) > 8'h1A)
    else $error("high flag rose below any level");
  a_quad_one_edge: assert property (
    $changed(enc_a_out) |-> $stable(enc_b_out))
    else $error("A and B moved together");
  a_abz_edge_gap: assert property (
    chg |-> gap_ff >= UPDATE_CYCLES - 1)
    else $error("encoder edges too close");
  // Low B before the rise means the zero quarter was entered forward
  a_index_on_a: assert property (
    $rose(enc_z_out) && !$past(enc_b_out) |-> $rose(enc_a_out))
    else $error("index without A rise");
  a_miso_idle: assert property (
    spi_cs_n_in [*5] |-> !spi_miso_oe_out)
    else $error("serial out driven while deselected");
  a_miso_drive: assert property (
    (!spi_cs_n_in) [*5] |-> spi_miso_oe_out)
    else $error("serial out not driven while selected");
  c_index: cover property ($rose(enc_z_out));
  c_high_set: cover property ($rose(high_field_flag_out));
  c_frame_end: cover property ($fell(spi_miso_oe_out));
endmodule : efflag_top_asserts
bind efflag_top efflag_top_asserts #(.UPDATE_CYCLES(UPDATE_CYCLES))
  i_efflag_top_asserts (.clk_in, .rst_n_in, .field_in, .spi_cs_n_in,
  .spi_miso_oe_out, .enc_a_out, .enc_b_out, .enc_z_out,
  .high_field_flag_out, .low_field_flag_out);

/* File: test/efflag_host.sv */
/* Host SPI master model: mode 0, 16-bit frames, MSB first.
   Assumes the device answers on the following frame. */
`timescale 1ns/1ns
module efflag_host (
  // SPI master pins
  output logic     sclk_out,
  output logic     cs_n_out,
  output logic     mosi_out,
  input wire logic miso_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Clock stands low between frames; MOSI flips once deselected
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_out = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = tx[i];
      #40 sclk_out = 1'b1;
      rx[i] = miso_in;
      #40 sclk_out = 1'b0;
    end
    #40 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #60;
  endtask : frame
endmodule : efflag_host

/* File: test/test_efflag_top.sv */
/* Self-checking bench for efflag_top: flags, registers, encoder.
   Assumes efflag_host as SPI master and a 125 MHz core clock. */
`timescale 1ns/1ns
module test_efflag_top;
  import efflag_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  angle = 8'h00;
  logic [7:0]  field = 8'h3C;
  logic        sclk, cs_n, mosi, miso, oe, a, b, z, hi_o, lo_o;
  logic [15:0] rx;
  int bad_count = 0, cmp_count = 0, seed = 45765;
  // Model codes start from the reset threshold register
  int na, nb, nz, f, hc = 7, lc = 0, hi = 0, lo = 1;
  int rise [8] = '{26, 41, 56, 70, 84, 98, 112, 126};
  int fall [8] = '{20, 35, 50, 64, 78, 92, 106, 120};
  initial forever #4 clk_in = ~clk_in;
  always @(posedge a) na++;
  always @(posedge b) nb++;
  always @(posedge z) nz++;
  efflag_top #(.UPDATE_CYCLES(2)) i_efflag_top (
    .clk_in, .rst_n_in, .angle_in(angle), .field_in(field),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(oe), .enc_a_out(a),
    .enc_b_out(b), .enc_z_out(z), .high_field_flag_out(hi_o),
    .low_field_flag_out(lo_o));
  efflag_host i_efflag_host (.sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi), .miso_in(oe ? miso : ~miso));
  // Undriven line reads inverted, so a late enable corrupts the reply
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic check(string what, int exp, logic [15:0] seen);
    cmp_count++;
    if (seen !== exp[15:0]) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(logic [2:0] cmd, logic [4:0] ad, logic [7:0] d);
    i_efflag_host.frame({cmd, ad, d}, rx);
    tick(1);
  endtask : xfer
  // The reply comes a frame late, so a read costs two frames
  task automatic rd(logic [4:0] ad);
    xfer(CMD_READ, ad, 8'h00);
    xfer(CMD_READ, ad, 8'h00);
  endtask : rd
  task automatic step(int v);
    field = v[7:0];
    tick(3);
    hi = v > rise[hc] ? 1 : v < fall[hc] ? 0 : hi;
    lo = v < fall[lc] ? 1 : v > rise[lc] ? 0 : lo;
    check("high pin", hi, hi_o);
    check("low pin", lo, lo_o);
  endtask : step
  task automatic turn(int n);
    na = 0;
    nb = 0;
    nz = 0;
    for (int i = 1; i <= 256; i++) begin
      angle = i[7:0];
      tick(4);
    end
    tick(8);
    check("a pulses", n, na[15:0]);
    check("b pulses", n, nb[15:0]);
    check("index count", 1, nz[15:0]);
  endtask : turn
  task automatic give_verdict;
    $display("mismatches %0d of %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
  initial begin
    tick(16);
    rst_n_in = 1'b1;
    tick(3);
    check("miso enable idle", 0, oe);
    // Flags settle on the reset codes before any frame
    step(field);
    rd(ADDR_THRESH);
    check("thr reset", THRESH_RESET[7:2], rx[15:10]);
    rd(5'h1F);
    check("unmapped", 0, rx[15:8]);
    for (int c = 0; c < 8; c++) begin
      hc = c;
      lc = 7 - c;
      xfer(CMD_WRITE, ADDR_THRESH, {lc[2:0], hc[2:0], 2'b00});
      // New codes act on the field already present
      step(field);
      rd(ADDR_THRESH);
      check("thr", {lc[2:0], hc[2:0]}, rx[15:10]);
      for (int k = 1; k <= 24; k++) begin
        f = ($random(seed) & 1) ? rise[$random(seed) & 7]
                                : fall[$random(seed) & 7];
        step(f + $random(seed) % 2);
        if (k % 8 == 0) begin
          xfer(CMD_WRITE, ADDR_STATUS, {~hi[0], ~lo[0], 6'h00});
          rd(ADDR_STATUS);
          check("status", {hi[0], lo[0]}, rx[15:14]);
        end
      end
    end
    turn(64);
    xfer(CMD_WRITE, ADDR_PPT_LO, 8'h40);
    xfer(CMD_WRITE, ADDR_PPT_HI, 8'h07);
    turn(30);
    xfer(CMD_WRITE, ADDR_PPT_LO, 8'h00);
    xfer(CMD_WRITE, ADDR_PPT_HI, 8'h00);
    turn(1);
    give_verdict();
  end
endmodule : test_efflag_top
